// ### logic/lwp_pkg.sv
// shared constants and types for the keypad wake pad control block
package lwp_pkg;
   // clock and wake hold timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int WAKE_HOLD_NS = 10000;
   localparam int WAKE_HOLD_CYC = (WAKE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_CNT_W = $clog2(WAKE_HOLD_CYC + 1);

   // register byte offsets
   localparam logic [7:0] ADDR_WAKE_CTRL = 8'h00;
   localparam logic [7:0] ADDR_PWR_CTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;

   // wake control register fields
   localparam int WC_IEN_LSB = 0;
   localparam int WC_POL_LSB = 4;
   localparam int WC_EDGE_LSB = 8;
   localparam int WC_LVL_LSB = 12;
   localparam int WC_HOST_BIT = 16;
   localparam int WC_W = 17;

   // power control register fields
   localparam int PC_SLEEP_BIT = 0;
   localparam int PC_HOLD_BIT = 1;
   localparam int PC_RETAIN_BIT = 2;

   // status register fields
   localparam int ST_PEND_LSB = 0;
   localparam int ST_LOWPWR_BIT = 4;
   localparam int ST_INIT_BIT = 5;
   localparam int ST_ACT_LSB = 8;

   // reset values
   localparam logic [3:0] IEN_RST = 4'h0;
   localparam logic [3:0] POL_RST = 4'hf;
   localparam logic [3:0] EDGE_RST = 4'h0;
   localparam logic [3:0] LVL_RST = 4'hf;

   // sleep unit states
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_SLEEP = 3'b010,
      ST_WAKE = 3'b100
   } lwp_state_t;

   // drive of the eight keypad pads (oe_b low while driving)
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe_b;
      logic [7:0] pu;
      logic [7:0] pd;
   } lwp_pad_t;

   // wake control register layout
   typedef struct packed {
      logic hostWake;
      logic [3:0] lvl;
      logic [3:0] edgeSel;
      logic [3:0] pol;
      logic [3:0] ien;
   } lwp_wctl_t;
endpackage

// ### logic/lwp_sync.sv
// multi-stage level synchroniser for the wake input pads
`timescale 1ns/1ps
`default_nettype none
module lwp_sync #(
   parameter int W = 4,
   parameter int STAGES = 2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] sh_r [STAGES];

   if (STAGES < 2) begin : g_chk
      $error("lwp_sync needs at least two stages");
   end

   // shift chain, only the last stage is visible
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < STAGES; i++) begin
            sh_r[i] <= '0;
         end
      end else begin
         sh_r[0] <= d;
         for (int i = 1; i < STAGES; i++) begin
            sh_r[i] <= sh_r[i-1];
         end
      end
   end

   assign q = sh_r[STAGES-1];
endmodule
`default_nettype wire

// ### logic/lwp_pad_ctrl.sv
// keypad wake pad control with apb registers and sleep sequencing
`timescale 1ns/1ps
`default_nettype none
module lwp_pad_ctrl
   import lwp_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int SYNC_STAGES = 2
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // apb slave
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // general pad controller request for run mode
   input wire lwp_pkg::lwp_pad_t gpioCtrl,
   // keypad pads
   input wire logic [7:0] padIn,
   output lwp_pkg::lwp_pad_t padDrv,
   // requests and power status
   output logic [3:0] irqReq,
   output logic wakeReq,
   output logic lowPower,
   output logic padPowerHold,
   output logic coreStateRetain
);
   import lwp_pkg::*;

   localparam int HoldCyc = WAKE_HOLD_CYC;

   if (ADDR_W < 4) begin : g_chk
      $error("lwp_pad_ctrl needs at least four address bits");
   end

   // byte strobes expanded to a bit mask
   function automatic logic [31:0] lwp_bmask(input logic [3:0] s);
      return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   lwp_state_t stateR, stateNxt;
   lwp_wctl_t wctlR, wctlNxt;
   logic initR;
   logic holdR;
   logic retainR;
   logic [3:0] pendR, pendNxt;
   logic [3:0] actPrevR;
   logic [WAKE_CNT_W-1:0] cntR, cntNxt;
   logic [31:0] prdataR;
   logic [3:0] padSync;

   // apb decode
   wire logic [7:0] addr8 = 8'(paddr);
   wire logic setup = psel & ~penable;
   wire logic access = psel & penable;
   wire logic selWc = addr8 == ADDR_WAKE_CTRL;
   wire logic selPc = addr8 == ADDR_PWR_CTRL;
   wire logic selSt = addr8 == ADDR_STATUS;
   wire logic mapped = selWc | selPc | selSt;
   wire logic wrEn = access & pwrite & mapped;
   wire logic [31:0] wmask = lwp_bmask(pstrb);
   wire logic wrWc = wrEn & selWc;
   wire logic wrPc = wrEn & selPc & pstrb[0];
   wire logic sleepReq = wrPc & pwdata[PC_SLEEP_BIT];
   wire logic [3:0] pendClr = (wrEn & selSt & pstrb[0]) ? pwdata[ST_PEND_LSB +: 4] : 4'h0;

   assign pready = 1'b1;
   assign pslverr = access & ~mapped;
   assign prdata = prdataR;

   // wake input sensing from the raw pads, no clock needed
   wire logic [3:0] rawAct = wctlR.ien & ~(padIn[7:4] ^ wctlR.pol);
   wire logic inSleep = stateR == ST_SLEEP;
   assign wakeReq = inSleep & (|rawAct);

   // clocked view of the same sensing
   lwp_sync #(
      .W(4),
      .STAGES(SYNC_STAGES)
   ) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .d(padIn[7:4]),
      .q(padSync)
   );
   wire logic [3:0] actSync = wctlR.ien & ~(padSync ^ wctlR.pol);
   wire logic [3:0] actRise = actSync & ~actPrevR & wctlR.edgeSel;
   wire logic wakeSync = |actSync;

   // set beats clear on the latched edge requests
   assign pendNxt = (pendR & ~pendClr) | actRise;
   // level requests pass straight from the pad, edge requests are latched
   assign irqReq = wctlR.ien & ((wctlR.edgeSel & pendR) | (~wctlR.edgeSel & rawAct));

   // wake control write with byte strobes
   assign wctlNxt = lwp_wctl_t'((WC_W'(wctlR) & ~wmask[WC_W-1:0]) | (pwdata[WC_W-1:0] & wmask[WC_W-1:0]));

   // sleep unit sequencing
   always_comb begin
      stateNxt = stateR;
      cntNxt = cntR;
      case (stateR)
         ST_RUN: begin
            if (sleepReq) begin
               stateNxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            cntNxt = '0;
            if (wakeSync) begin
               stateNxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            cntNxt = cntR + WAKE_CNT_W'(1);
            if (cntR == WAKE_CNT_W'(HoldCyc - 1)) begin
               stateNxt = ST_RUN;
            end
         end
         default: begin
            stateNxt = ST_RUN;
         end
      endcase
   end

   // state and register storage
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         stateR <= ST_RUN;
         wctlR <= '{hostWake: 1'b0, lvl: LVL_RST, edgeSel: EDGE_RST, pol: POL_RST, ien: IEN_RST};
         initR <= 1'b0;
         holdR <= 1'b0;
         retainR <= 1'b0;
         pendR <= 4'h0;
         actPrevR <= 4'h0;
         cntR <= '0;
      end else begin
         stateR <= stateNxt;
         cntR <= cntNxt;
         pendR <= pendNxt;
         actPrevR <= actSync;
         if (wrWc) begin
            wctlR <= wctlNxt;
            initR <= 1'b1;
         end
         if (wrPc) begin
            holdR <= pwdata[PC_HOLD_BIT];
            retainR <= pwdata[PC_RETAIN_BIT];
         end
      end
   end

   // read data captured in the setup cycle
   wire logic [31:0] rdStatus = {16'h0, 4'h0, actSync, 2'h0, initR, lowPower, pendR};
   wire logic [31:0] rdPwr = {29'h0, retainR, holdR, 1'b0};
   wire logic [31:0] rdMux = selWc ? 32'(wctlR) : selPc ? rdPwr : selSt ? rdStatus : 32'h0;
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         prdataR <= 32'h0;
      end else if (setup & ~pwrite) begin
         prdataR <= rdMux;
      end
   end

   // power status outputs
   assign lowPower = stateR != ST_RUN;
   assign padPowerHold = holdR & retainR; // hold ignored without retention
   assign coreStateRetain = retainR;

   // power unit pad drive: levels before init are the defaults
   wire logic [3:0] lvlEff = initR ? wctlR.lvl : LVL_RST;
   wire logic hostLvl = stateR == ST_WAKE;
   wire logic [3:0] lowOut = wctlR.hostWake ? {lvlEff[3:1], hostLvl} : lvlEff;
   wire logic [3:0] upPu = initR ? ~wctlR.pol : 4'h0;
   wire logic [3:0] upPd = initR ? wctlR.pol : 4'hf;
   wire lwp_pad_t pmuPad = '{out: {4'h0, lowOut}, oe_b: 8'hf0, pu: {upPu, 4'h0}, pd: {upPd, 4'h0}};

   // ownership: reset and every non-run state belong to the power unit,
   // whatever the pad power hold says; the keypad pads are never unpowered
   wire logic pmuOwn = ~rst_b | lowPower;
   assign padDrv = pmuOwn ? pmuPad : gpioCtrl;

   // cycles spent in the wake state, watched by the hold length checks
   logic [WAKE_CNT_W-1:0] wakeLenR;
   always_ff @(posedge ref_clk) begin
      if (!rst_b || !(stateR == ST_WAKE)) begin
         wakeLenR <= '0;
      end else begin
         wakeLenR <= wakeLenR + WAKE_CNT_W'(1);
      end
   end

   // checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_b);

   property p_dir;
      lowPower |-> (padDrv.oe_b[7:4] == 4'hf) && (padDrv.oe_b[3:0] == 4'h0);
   endproperty
   a_dir: assert property (p_dir) else $error("keypad pad directions wrong in low power");

   property p_own;
      (stateR == ST_RUN) |-> (padDrv == gpioCtrl);
   endproperty
   a_own: assert property (p_own) else $error("pad controller lost pads in run");

   property p_hostlow;
      (inSleep && wctlR.hostWake) |-> !padDrv.out[0];
   endproperty
   a_hostlow: assert property (p_hostlow) else $error("host wake pad not low in sleep");

   property p_hosthigh;
      ($rose(stateR == ST_WAKE) && wctlR.hostWake) |-> padDrv.out[0] [*3];
   endproperty
   a_hosthigh: assert property (p_hosthigh) else $error("host wake pad not high on wake");

   property p_mask;
      (irqReq & ~wctlR.ien) == 4'h0;
   endproperty
   a_mask: assert property (p_mask) else $error("masked input raised a request");

   property p_latch;
      (pendR[0] && !pendClr[0]) |=> pendR[0];
   endproperty
   a_latch: assert property (p_latch) else $error("edge request dropped before clear");

   property p_wake;
      (inSleep && wakeSync) |=> (stateR == ST_WAKE);
   endproperty
   a_wake: assert property (p_wake) else $error("enabled input did not wake");

   property p_exit;
      $fell(stateR == ST_WAKE) |-> ($past(wakeLenR) == WAKE_CNT_W'(HoldCyc - 1));
   endproperty
   a_exit: assert property (p_exit) else $error("wake hold length wrong");

   property p_wakemax;
      (stateR == ST_WAKE) |-> (wakeLenR < WAKE_CNT_W'(HoldCyc));
   endproperty
   a_wakemax: assert property (p_wakemax) else $error("wake state held too long");

   property p_sleepent;
      ((stateR == ST_RUN) && sleepReq) |=> inSleep;
   endproperty
   a_sleepent: assert property (p_sleepent) else $error("sleep request not taken in run");

   property p_runlp;
      (stateR == ST_RUN) |-> !lowPower;
   endproperty
   a_runlp: assert property (p_runlp) else $error("low power shown in run");

   property p_quiet;
      (wctlR.ien == 4'h0) |-> !wakeReq && (irqReq == 4'h0);
   endproperty
   a_quiet: assert property (p_quiet) else $error("disabled inputs raised a request");

   property p_holdret;
      padPowerHold |-> coreStateRetain;
   endproperty
   a_holdret: assert property (p_holdret) else $error("pad power hold without retention");

   property p_ready;
      (psel && penable) |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access phase not answered");

   property p_slverr;
      (psel && penable && !mapped) |-> pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access without error");

   property p_unmapped;
      (psel && penable && !pwrite && !mapped) |-> (prdata == 32'h0);
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");

   property p_pull;
      (lowPower && initR) |-> (padDrv.pu[7:4] == ~wctlR.pol) && (padDrv.pd[7:4] == wctlR.pol);
   endproperty
   a_pull: assert property (p_pull) else $error("wake pad pulls do not follow polarity");

   property p_lvl;
      (inSleep && !wctlR.hostWake) |-> (padDrv.out[3:0] == (initR ? wctlR.lvl : LVL_RST));
   endproperty
   a_lvl: assert property (p_lvl) else $error("sleep output levels wrong");
endmodule
`default_nettype wire

// ### test/lwp_wake_src.sv
// wake source and pad wire model for the keypad pads
`timescale 1ns/1ps
`default_nettype none
module lwp_wake_src
   import lwp_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // block pad drive and source enables (source drives high)
   input wire lwp_pkg::lwp_pad_t padDrv,
   input wire logic [7:0] srcEn,
   // resolved pad levels
   output logic [7:0] padIn
);
   logic [7:0] lastR;
   // remember the last driven or pulled level; a floating pad shows its inverse
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 8; i++) begin
         if (!padDrv.oe_b[i] || srcEn[i] || padDrv.pu[i] || padDrv.pd[i]) begin
            lastR[i] <= padIn[i];
         end
      end
   end
   // wire level from block drive, source drive and pulls
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!padDrv.oe_b[i]) padIn[i] = padDrv.out[i];
         else if (srcEn[i]) padIn[i] = 1'b1;
         else if (padDrv.pu[i]) padIn[i] = 1'b1;
         else if (padDrv.pd[i]) padIn[i] = 1'b0;
         else padIn[i] = ~lastR[i];
      end
   end
endmodule
`default_nettype wire

// ### test/lwp_pad_ctrl_tb.sv
// self-checking bench for the keypad wake pad control block
`timescale 1ns/1ps
`default_nettype none
module lwp_pad_ctrl_tb;
   import lwp_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, wakeReq, lowPower, padPowerHold, coreStateRetain;
   logic [3:0] irqReq;
   logic [7:0] padIn;
   logic [7:0] srcEn = 8'h00;
   lwp_pad_t gpioCtrl = '0;
   lwp_pad_t padDrv;
   lwp_wctl_t wc;
   logic [15:0] rnd = 16'h0063;
   logic [32:0] expQ[$];
   int n_mismatch = 0;
   int n_tests = 0;
   int n;

   lwp_pad_ctrl i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gpioCtrl(gpioCtrl), .padIn(padIn), .padDrv(padDrv), .irqReq(irqReq), .wakeReq(wakeReq),
      .lowPower(lowPower), .padPowerHold(padPowerHold), .coreStateRetain(coreStateRetain));
   lwp_wake_src i_src (.ref_clk(ref_clk), .padDrv(padDrv), .srcEn(srcEn), .padIn(padIn));

   // free-running clock
   initial begin
      forever begin
         #10 ref_clk = ~ref_clk;
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic end_of_test();
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("ERROR %s exp %h got %h", nm, e, g);
         n_mismatch++;
      end
   endtask

   task automatic tmo(input int c, input int lim);
      if (c >= lim) begin
         $display("ERROR wait exp done got %0d cycles", c);
         n_mismatch++;
         end_of_test();
      end
   endtask

   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic src(input logic [7:0] v);
      @(posedge ref_clk);
      srcEn <= v;
      #1;
   endtask

   // one apb transfer; a read notes its expected {pslverr, prdata}
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int c;
      if (!w) expQ.push_back(e);
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      c = 0;
      do begin
         @(posedge ref_clk);
         c++;
      end while (pready !== 1'b1 && c < 20);
      tmo(c, 20);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // read answers compared against the oldest note
   always @(posedge ref_clk) begin
      logic [32:0] e;
      if (psel && penable && pready && !pwrite) begin
         e = expQ.pop_front();
         n_tests++;
         if ({pslverr, prdata} !== e) begin
            $display("ERROR apbRead exp %h got %h", e, {pslverr, prdata});
            n_mismatch++;
         end
      end
   end

   // main sequence
   initial begin
      rnd = lfsr(rnd);
      gpioCtrl <= '{out: rnd[7:0], oe_b: {4'hf, rnd[11:8]}, pu: 8'h00, pd: 8'hf0};
      repeat (11) @(posedge ref_clk);
      #1;
      chk("rstOe", 32'hf0, 32'(padDrv.oe_b));
      chk("rstOut", 32'hf, 32'(padDrv.out[3:0]));
      chk("rstPd", 32'hf, 32'(padDrv.pd[7:4]));
      @(posedge ref_clk);
      rst_b <= 1'b1;
      tick();
      chk("runDrv", gpioCtrl, padDrv);
      apb(1'b0, ADDR_WAKE_CTRL, 32'h0, {1'b0, 32'h0000f0f0});
      apb(1'b0, 8'h0c, 32'h0, {1'b1, 32'h0});
      rnd = lfsr(rnd);
      wc = '{hostWake: 1'b1, lvl: rnd[3:0], edgeSel: 4'h0, pol: 4'h3, ien: 4'h1};
      apb(1'b1, ADDR_WAKE_CTRL, 32'(wc), 33'h0);
      apb(1'b0, ADDR_WAKE_CTRL, 32'h0, {1'b0, 32'(wc)});
      apb(1'b1, ADDR_PWR_CTRL, 32'h7, 33'h0);
      tick();
      chk("slpLow", 32'h1, 32'(lowPower));
      chk("slpOe", 32'hf0, 32'(padDrv.oe_b));
      chk("slpOut", 32'({wc.lvl[3:1], 1'b0}), 32'(padDrv.out[3:0]));
      chk("slpPull", 32'({~wc.pol, wc.pol}), 32'({padDrv.pu[7:4], padDrv.pd[7:4]}));
      chk("hold", 32'h3, 32'({padPowerHold, coreStateRetain}));
      src(8'h20);
      chk("maskWake", 32'h0, 32'(wakeReq));
      src(8'h30);
      chk("wake", 32'h1, 32'(wakeReq));
      for (n = 0; n < 20 && padDrv.out[0] !== 1'b1; n++) begin
         tick();
      end
      tmo(n, 20);
      chk("wakeOe", 32'hf0, 32'(padDrv.oe_b));
      for (n = 0; n < 600 && lowPower !== 1'b0; n++) begin
         tick();
      end
      tmo(n, 600);
      chk("wakeLen", 32'(WAKE_HOLD_CYC), 32'(n));
      chk("backDrv", gpioCtrl, padDrv);
      chk("lvlIrq", 32'h1, 32'(irqReq));
      src(8'h00);
      wc.edgeSel = 4'h1;
      apb(1'b1, ADDR_WAKE_CTRL, 32'(wc), 33'h0);
      src(8'h10);
      for (n = 0; n < 20 && irqReq[0] !== 1'b1; n++) begin
         tick();
      end
      tmo(n, 20);
      src(8'h00);
      repeat (4) tick();
      chk("latched", 32'h1, 32'(irqReq));
      apb(1'b0, ADDR_STATUS, 32'h0, {1'b0, 32'h21});
      apb(1'b1, ADDR_STATUS, 32'h1, 33'h0);
      tick();
      chk("cleared", 32'h0, 32'(irqReq));
      // second sleep: plain levels on every lower pad, hold without retention
      wc.hostWake = 1'b0;
      apb(1'b1, ADDR_WAKE_CTRL, 32'(wc), 33'h0);
      apb(1'b1, ADDR_PWR_CTRL, 32'h3, 33'h0);
      tick();
      chk("slpLvl", 32'(wc.lvl), 32'(padDrv.out[3:0]));
      chk("holdNoRet", 32'h0, 32'({padPowerHold, coreStateRetain}));
      // reset in mid-sleep returns the block to run with defaults
      @(posedge ref_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_b <= 1'b1;
      tick();
      chk("rstRun", 32'h0, 32'(lowPower));
      chk("rstDrv", gpioCtrl, padDrv);
      apb(1'b0, ADDR_WAKE_CTRL, 32'h0, {1'b0, 32'h0000f0f0});
      tick();
      chk("drained", 32'h0, 32'(expQ.size()));
      end_of_test();
   end
endmodule
`default_nettype wire
